// ===== rtl/vf_msg_interrupt_pkg.sv
// Constants for the per-vector message interrupt table and pending array
package vf_msg_interrupt_pkg;
	localparam int          NUM_VECTORS      = 65;
	localparam int          VEC_IDX_W        = 7;
	localparam int          BAR_ADDR_W       = 16;
	localparam int          PBA_WORDS        = 3;
	localparam logic [15:0] TABLE_STRIDE     = 16'h0010;
	localparam logic [15:0] TABLE_END        = 16'h0410;
	localparam logic [3:0]  ENTRY_ADDR_LOW   = 4'h0;
	localparam logic [3:0]  ENTRY_ADDR_HIGH  = 4'h4;
	localparam logic [3:0]  ENTRY_DATA       = 4'h8;
	localparam logic [3:0]  ENTRY_CONTROL    = 4'hc;
	localparam logic [15:0] PBA_BASE         = 16'h8000;
	localparam logic [15:0] PBA_END          = 16'h800c;
	localparam int          ALIGN_MSB        = 1;
	localparam int          MASK_BIT         = 0;
	localparam logic [31:0] ADDR_LOW_RESET   = 32'h0000_0000;
	localparam logic [31:0] ADDR_HIGH_RESET  = 32'h0000_0000;
	localparam logic [31:0] DATA_RESET       = 32'h0000_0000;
	localparam logic        MASK_RESET       = 1'h1;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
endpackage

// ===== rtl/vf_msg_interrupt_table.sv
// Message interrupt table, pending array and interrupt write issue
//
// Behaviour
// - Alignment bits reset to zero; here they are read-only zero.
// - Low address bits 31:2 form the dword-aligned write address.
// - Zero high address gives single address cycle, otherwise dual.
// - Stored data word is the payload of the interrupt write.
// - A masked entry sends nothing; other entries are unaffected.
// - Mask bit resets to one, other control bits to zero.
// - Pending bit is set by its request and cleared when its write is taken.
// - Entries decode at 16-byte stride, 65 entries, four words each.
// - Pending array is three read-only words at 0x8000.
`timescale 1ns/1ps
`default_nettype none
module vf_msg_interrupt_table (
	input  wire logic        i_core_clk,     // Core clock, 20 MHz
	input  wire logic        i_rst,          // Synchronous reset, active high
	input  wire logic        i_bar_wr,       // BAR write strobe
	input  wire logic        i_bar_rd,       // BAR read strobe
	input  wire logic [15:0] i_bar_addr,     // BAR byte address
	input  wire logic [31:0] i_bar_wdata,    // BAR write data
	output logic [31:0]      o_bar_rdata,    // BAR read data
	output logic             o_bar_rvalid,   // Read data valid pulse
	input  wire logic [64:0] i_irq_event,    // Interrupt request pulse per vector
	output logic             o_msg_valid,    // Interrupt write pending to host
	input  wire logic        i_msg_ready,    // Host side takes the write
	output logic [63:0]      o_msg_addr,     // Write address
	output logic             o_msg_dual,     // Dual address cycle
	output logic [31:0]      o_msg_data,     // Write payload
	output logic [6:0]       o_msg_vector    // Vector being signalled
);
	typedef enum logic {ST_IDLE, ST_SEND} send_state_t;

	logic [29:0] addr_low  [65];
	logic [31:0] addr_high [65];
	logic [31:0] msg_data  [65];
	logic [64:0] mask;
	logic [64:0] pending;
	send_state_t state;
	logic [6:0]  cur_vec;

	logic [29:0] next_addr_low  [65];
	logic [31:0] next_addr_high [65];
	logic [31:0] next_msg_data  [65];
	logic [64:0] next_mask;
	logic [64:0] next_pending;
	send_state_t next_state;
	logic [6:0]  next_cur_vec;
	logic [31:0] next_rdata;
	logic        next_rvalid;
	logic        next_msg_valid;
	logic [63:0] next_msg_addr;
	logic        next_msg_dual;
	logic [31:0] next_msg_data_o;
	logic [6:0]  next_msg_vector;

	logic        in_table;
	logic        in_pba;
	logic [6:0]  acc_vec;
	logic [3:0]  acc_word;
	logic [1:0]  pba_idx;
	logic        pick_found;
	logic [6:0]  pick_index;
	logic [95:0] pba_wide;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign in_table = (i_bar_addr < vf_msg_interrupt_pkg::TABLE_END);
	assign in_pba   = (i_bar_addr >= vf_msg_interrupt_pkg::PBA_BASE) &&
	                  (i_bar_addr < vf_msg_interrupt_pkg::PBA_END);
	assign acc_vec  = i_bar_addr[10:4];
	assign acc_word = {i_bar_addr[3:2], 2'b00};
	assign pba_idx  = i_bar_addr[3:2];
	assign pba_wide = {31'h0000_0000, pending};

	vf_msg_vector_pick u_pick (
		.i_ready (pending & ~mask),
		.o_found (pick_found),
		.o_index (pick_index)
	);

	// ------------------------------------------------------------
	// Table storage and read path
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < vf_msg_interrupt_pkg::NUM_VECTORS; i++) begin
			next_addr_low[i]  = addr_low[i];
			next_addr_high[i] = addr_high[i];
			next_msg_data[i]  = msg_data[i];
		end
		next_mask   = mask;
		next_rdata  = vf_msg_interrupt_pkg::UNMAPPED_READ;
		next_rvalid = i_bar_rd;
		if (i_bar_wr && in_table) begin
			if (acc_word == vf_msg_interrupt_pkg::ENTRY_ADDR_LOW) begin
				next_addr_low[acc_vec] = i_bar_wdata[31:vf_msg_interrupt_pkg::ALIGN_MSB+1];
			end else if (acc_word == vf_msg_interrupt_pkg::ENTRY_ADDR_HIGH) begin
				next_addr_high[acc_vec] = i_bar_wdata;
			end else if (acc_word == vf_msg_interrupt_pkg::ENTRY_DATA) begin
				next_msg_data[acc_vec] = i_bar_wdata;
			end else begin
				next_mask[acc_vec] = i_bar_wdata[vf_msg_interrupt_pkg::MASK_BIT];
			end
		end
		if (i_bar_rd && in_table) begin
			if (acc_word == vf_msg_interrupt_pkg::ENTRY_ADDR_LOW) begin
				next_rdata = {addr_low[acc_vec], 2'b00};
			end else if (acc_word == vf_msg_interrupt_pkg::ENTRY_ADDR_HIGH) begin
				next_rdata = addr_high[acc_vec];
			end else if (acc_word == vf_msg_interrupt_pkg::ENTRY_DATA) begin
				next_rdata = msg_data[acc_vec];
			end else begin
				next_rdata = {31'h0000_0000, mask[acc_vec]};
			end
		end else if (i_bar_rd && in_pba) begin
			next_rdata = pba_wide[pba_idx*32 +: 32];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int i = 0; i < vf_msg_interrupt_pkg::NUM_VECTORS; i++) begin
				addr_low[i]  <= vf_msg_interrupt_pkg::ADDR_LOW_RESET[31:2];
				addr_high[i] <= vf_msg_interrupt_pkg::ADDR_HIGH_RESET;
				msg_data[i]  <= vf_msg_interrupt_pkg::DATA_RESET;
			end
			mask        <= {65{vf_msg_interrupt_pkg::MASK_RESET}};
			o_bar_rdata  <= vf_msg_interrupt_pkg::UNMAPPED_READ;
			o_bar_rvalid <= 1'b0;
		end else begin
			for (int i = 0; i < vf_msg_interrupt_pkg::NUM_VECTORS; i++) begin
				addr_low[i]  <= next_addr_low[i];
				addr_high[i] <= next_addr_high[i];
				msg_data[i]  <= next_msg_data[i];
			end
			mask        <= next_mask;
			o_bar_rdata  <= next_rdata;
			o_bar_rvalid <= next_rvalid;
		end
	end

	// ------------------------------------------------------------
	// Pending bits and interrupt write issue
	// ------------------------------------------------------------
	always_comb begin
		next_pending    = pending;
		next_state      = state;
		next_cur_vec    = cur_vec;
		next_msg_valid  = o_msg_valid;
		next_msg_addr   = o_msg_addr;
		next_msg_dual   = o_msg_dual;
		next_msg_data_o = o_msg_data;
		next_msg_vector = o_msg_vector;
		case (state)
			ST_IDLE: begin
				if (pick_found) begin
					next_state      = ST_SEND;
					next_cur_vec    = pick_index;
					next_msg_valid  = 1'b1;
					next_msg_addr   = {addr_high[pick_index], addr_low[pick_index], 2'b00};
					next_msg_dual   = (addr_high[pick_index] != 32'h0000_0000);
					next_msg_data_o = msg_data[pick_index];
					next_msg_vector = pick_index;
				end
			end
			ST_SEND: begin
				if (i_msg_ready) begin
					next_state     = ST_IDLE;
					next_msg_valid = 1'b0;
					next_pending[cur_vec] = 1'b0;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// A new request in the clearing cycle wins
		next_pending = next_pending | i_irq_event;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pending      <= 65'h0;
			state        <= ST_IDLE;
			cur_vec      <= 7'h00;
			o_msg_valid  <= 1'b0;
			o_msg_addr   <= 64'h0;
			o_msg_dual   <= 1'b0;
			o_msg_data   <= 32'h0;
			o_msg_vector <= 7'h00;
		end else begin
			pending      <= next_pending;
			state        <= next_state;
			cur_vec      <= next_cur_vec;
			o_msg_valid  <= next_msg_valid;
			o_msg_addr   <= next_msg_addr;
			o_msg_dual   <= next_msg_dual;
			o_msg_data   <= next_msg_data_o;
			o_msg_vector <= next_msg_vector;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/vf_msg_vector_pick.sv
// Lowest-index picker of vectors that are pending and unmasked
`timescale 1ns/1ps
`default_nettype none
module vf_msg_vector_pick (
	input  wire logic [64:0] i_ready,  // Pending and unmasked per vector
	output logic             o_found,  // Some vector is ready
	output logic [6:0]       o_index   // Lowest ready vector
);
	always_comb begin
		o_found = 1'b0;
		o_index = 7'h00;
		for (int i = 64; i >= 0; i--) begin
			if (i_ready[i]) begin
				o_found = 1'b1;
				o_index = 7'(i);
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/host_msg_sink.sv
// Host model that takes interrupt writes
`timescale 1ns/1ps
`default_nettype none
module host_msg_sink (
	input wire logic        i_core_clk, // Clock
	input wire logic        i_slow,     // Stall every other cycle
	input wire logic        i_valid,    // Offer
	input wire logic [63:0] i_addr,     // Address
	input wire logic [31:0] i_data,     // Payload
	input wire logic        i_dual,     // Dual
	input wire logic [6:0]  i_vector,   // Vector
	output logic            o_ready,    // Accept
	output logic [103:0]    o_last,     // Last write taken
	output int              o_count     // Writes taken
);
	initial begin
		o_ready = 1'b0;
		o_count = 0;
	end
	always @(posedge i_core_clk) begin
		if (i_valid && o_ready) begin
			o_last <= {i_dual, i_vector, i_addr, i_data};
			o_count <= o_count + 1;
		end
		o_ready <= i_slow ? !o_ready : 1'b1;
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the message interrupt table
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic         slow = 1'b0;
	logic [15:0]  addr = 16'h0;
	logic [31:0]  wdata = 32'h0;
	logic [64:0]  irq = '0;
	logic [31:0]  rdata, mdata;
	logic         rvalid, mvalid, mready, mdual;
	logic [63:0]  maddr;
	logic [6:0]   mvec;
	logic [103:0] last;
	int           count;
	int           fails = 0;
	int           checked = 0;
	always #25 clk = ~clk;
	vf_msg_interrupt_table uut (.i_core_clk(clk), .i_rst(rst), .i_bar_wr(wr), .i_bar_rd(rd), .i_bar_addr(addr),
		.i_bar_wdata(wdata), .o_bar_rdata(rdata), .o_bar_rvalid(rvalid), .i_irq_event(irq), .o_msg_valid(mvalid),
		.i_msg_ready(mready), .o_msg_addr(maddr), .o_msg_dual(mdual), .o_msg_data(mdata), .o_msg_vector(mvec));
	host_msg_sink host (.i_core_clk(clk), .i_slow(slow), .i_valid(mvalid), .i_addr(maddr), .i_data(mdata),
		.i_dual(mdual), .i_vector(mvec), .o_ready(mready), .o_last(last), .o_count(count));
	task automatic chk(input string what, input logic [103:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rvalid", rvalid, 1'b1);
		chk("rdata", rdata, exp);
	endtask
	task automatic ev(input int n);
		@(posedge clk);
		irq <= 65'h1 << n;
		@(posedge clk);
		irq <= '0;
	endtask
	// Program an entry, unmask it and compare the write taken
	task automatic fire(input int n, input logic [31:0] lo, hi, d);
		int c0;
		c0 = count;
		wr_reg(16'(n * 16), lo);
		wr_reg(16'(n * 16 + 4), hi);
		wr_reg(16'(n * 16 + 8), d);
		wr_reg(16'(n * 16 + 12), 32'h0);
		for (int i = 0; i < 20 && count == c0; i++) @(posedge clk);
		chk("message", last, {hi != 32'h0, 7'(n), hi, lo[31:2], 2'h0, d});
	endtask
	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_chk(16'h040c, 32'h1);
		rd_chk(16'h0400, 32'h0);
		rd_chk(16'h8004, 32'h0);
		ev(3);
		ev(64);
		ev(5);
		wr_reg(16'h8000, 32'hffff_ffff);
		repeat (4) @(posedge clk);
		chk("sent", count, 0);
		rd_chk(16'h8000, 32'h28);
		rd_chk(16'h8008, 32'h1);
		rd_chk(16'h0410, 32'h0);
		fire(3, 32'h1234_5678, 32'h0, 32'hdead_beef);
		rd_chk(16'h0030, 32'h1234_5678);
		slow <= 1'b1;
		fire(64, 32'habcd_0004, 32'h1, 32'h40);
		rd_chk(16'h8000, 32'h20);
		rd_chk(16'h8008, 32'h0);
		// A second request on a masked, pending entry merges into one write
		ev(5);
		fire(5, 32'h0000_0100, 32'h0, 32'h5);
		repeat (6) @(posedge clk);
		chk("merged", count, 3);
		rd_chk(16'h8000, 32'h0);
		// Reset in mid-run brings masks and table back to their reset values
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_chk(16'h003c, 32'h1);
		rd_chk(16'h0030, 32'h0);
		rd_chk(16'h0034, 32'h0);
		summarize();
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire

// ===== tb/vf_msg_interrupt_monitor.sv
// Port checker for the message interrupt table
`timescale 1ns/1ps
`default_nettype none
module vf_msg_interrupt_monitor (
	input wire logic        i_core_clk,   // Clock
	input wire logic        i_rst,        // Reset
	input wire logic        i_bar_wr,     // Write
	input wire logic        i_bar_rd,     // Read
	input wire logic        o_bar_rvalid, // Read valid
	input wire logic        o_msg_valid,  // Offer
	input wire logic        i_msg_ready,  // Accept
	input wire logic [63:0] o_msg_addr,   // Address
	input wire logic        o_msg_dual,   // Dual
	input wire logic [6:0]  o_msg_vector  // Vector
);
	logic wr_seen;
	logic next_wr_seen;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Set by the first write after reset
	always_comb next_wr_seen = !i_rst && (wr_seen || i_bar_wr);
	always_ff @(posedge i_core_clk) wr_seen <= next_wr_seen;
	AST_HOLD: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg_addr))
		else $error("offer dropped");
	AST_ALIGN: assert property (o_msg_valid |-> o_msg_addr[1:0] == 2'h0)
		else $error("address unaligned");
	AST_DUAL: assert property (o_msg_valid |-> o_msg_dual == (o_msg_addr[63:32] != 32'h0))
		else $error("dual wrong");
	AST_RVALID: assert property (i_bar_rd |=> o_bar_rvalid)
		else $error("no read valid");
	AST_NO_RVALID: assert property (!i_bar_rd |=> !o_bar_rvalid)
		else $error("stray read valid");
	AST_GAP: assert property (o_msg_valid && i_msg_ready |=> !o_msg_valid)
		else $error("no idle cycle");
	AST_VEC: assert property (o_msg_valid |-> o_msg_vector <= 7'h40)
		else $error("vector range");
	AST_MASKED: assert property (!wr_seen |-> !o_msg_valid)
		else $error("masked entry sent");
	cover property (o_msg_valid && i_msg_ready && o_msg_dual);
	cover property (o_msg_valid && i_msg_ready && !o_msg_dual);
	cover property (o_msg_valid && !i_msg_ready);
endmodule
bind vf_msg_interrupt_table vf_msg_interrupt_monitor mon (.i_core_clk, .i_rst, .i_bar_wr, .i_bar_rd,
	.o_bar_rvalid, .o_msg_valid, .i_msg_ready, .o_msg_addr, .o_msg_dual, .o_msg_vector);
`default_nettype wire
